// ### hdl/tcc_timer16.sv
// Sixteen-bit timer counter with input capture and shared high byte
// Operation
// [R01] Software keeps shared-byte sequences uninterrupted
// [R02] Tick source chosen by three-bit select
// [R03] Sixteen-bit up/down counter with top, bottom
// [R04] Upper byte accesses go to holding register
// [R05] Lower read loads holder; lower write loads counter
// [R06] Each tick clears, increments or decrements
// [R07] Select zero stops; CPU access always works
// [R08] CPU write beats count and clear
// [R09] Sequence from four-bit waveform mode field
// [R10] Overflow flag set per mode, interruptible
// [R11] Qualified edge copies counter into capture
// [R12] Capture flag set in copy cycle
// [R13] Capture interrupt; flag cleared by ack/one
// [R14] Capture read lower first via holder
// [R15] Capture writable only as top value
// [R16] Software sets mode before top, upper first
// [R17] Comparator source select; software clears flag
// [R18] Filter changes after four equal samples
// [R19] Filter enable bit adds four cycles
// [R20] Capture input active unless capture is top
// [R21] New capture overwrites unread value
// [R22] Port-driven pin change also captures
// [R23] Lower write stores both bytes at once
// [R24] Bottom is zero, maximum is all ones
// [R25] Edge select chooses rising or falling
// [R26] Pins synchronised before filtering
`timescale 1ns/1ns
`default_nettype none
module tcc_timer16
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // CPU byte port
  input  wire logic [2:0] cpuSel,
  input  wire logic       cpuRead,
  input  wire logic       cpuWrite,
  input  wire logic [7:0] cpuWdata,
  output logic      [7:0] cpuRdata,
  // Tick sources
  input  wire logic [7:0] prescaleTicks,
  input  wire logic       external_count_pin,
  // Capture sources
  input  wire logic       capture_pin,
  input  wire logic       comparator_output,
  input  wire logic       comparator_capture_select,
  // Flags and interrupts
  input  wire logic       capture_irq_enable,
  input  wire logic       overflow_irq_enable,
  input  wire logic       captureIrqAck,
  input  wire logic       overflowIrqAck,
  input  wire logic       captureFlagClear,
  input  wire logic       overflowFlagClear,
  output logic            capture_flag,
  output logic            counter_overflow_flag,
  output logic            captureIrq,
  output logic            overflowIrq,
  // Counter status towards compare logic
  input  wire logic [15:0] compareTop,
  output logic      [15:0] timer_count,
  output logic             countTop,
  output logic             countBottom,
  output logic             timer_tick
);
  logic [7:0]  timer_control_first;
  logic [7:0]  timer_control_second;
  logic [7:0]  holdByte;
  logic [15:0] capture_value;
  logic        countDown;
  logic        extSyncA;
  logic        extSyncB;
  logic        extLast;
  logic        captureEvent;
  logic        captureSource;
  logic [3:0]  waveform_mode_field;
  logic [2:0]  tick_source_select;
  tcc_pkg::tcc_seq_t    seqMode;
  tcc_pkg::tcc_topsrc_t topSrc;
  logic [15:0] topValue;
  logic        atTop;
  logic        captureIsTop;
  logic        overflowEvent;
  logic [15:0] next_count;
  logic        next_countDown;

  // Access strobes
  logic wrCountLo;
  logic rdCountLo;
  logic wrCaptLo;
  logic rdCaptLo;
  logic wrHold;
  assign wrCountLo = cpuWrite && (cpuSel == tcc_pkg::SEL_COUNT_LO);
  assign rdCountLo = cpuRead && (cpuSel == tcc_pkg::SEL_COUNT_LO);
  assign wrCaptLo  = cpuWrite && (cpuSel == tcc_pkg::SEL_CAPT_LO);
  assign rdCaptLo  = cpuRead && (cpuSel == tcc_pkg::SEL_CAPT_LO);
  assign wrHold    = cpuWrite && ((cpuSel == tcc_pkg::SEL_COUNT_HI)
                     || (cpuSel == tcc_pkg::SEL_CAPT_HI)); // [R04]

  assign tick_source_select =
    timer_control_second[tcc_pkg::CTRLB_CS_LO +: 3];
  assign waveform_mode_field =
    {timer_control_second[tcc_pkg::CTRLB_WGM_LO +: 2],
     timer_control_first[tcc_pkg::CTRLA_WGM_LO +: 2]}; // [R09]

  // Mode decode: sequence and source of top
  always_comb
  begin
    seqMode  = tcc_pkg::SEQ_UP_MAX;
    topSrc   = tcc_pkg::TOP_FIXED;
    topValue = tcc_pkg::COUNT_MAX;
    case (waveform_mode_field)
      4'h1, 4'h5:
      begin
        topValue = tcc_pkg::TOP_8BIT;
        seqMode  = (waveform_mode_field == 4'h1) ? tcc_pkg::SEQ_UPDOWN
                                                 : tcc_pkg::SEQ_UP_TOP;
      end
      4'h2, 4'h6:
      begin
        topValue = tcc_pkg::TOP_9BIT;
        seqMode  = (waveform_mode_field == 4'h2) ? tcc_pkg::SEQ_UPDOWN
                                                 : tcc_pkg::SEQ_UP_TOP;
      end
      4'h3, 4'h7:
      begin
        topValue = tcc_pkg::TOP_10BIT;
        seqMode  = (waveform_mode_field == 4'h3) ? tcc_pkg::SEQ_UPDOWN
                                                 : tcc_pkg::SEQ_UP_TOP;
      end
      4'h4, 4'hF:
      begin
        topSrc   = tcc_pkg::TOP_COMPARE;
        topValue = compareTop;
        seqMode  = tcc_pkg::SEQ_UP_TOP;
      end
      4'h8, 4'hA:
      begin
        topSrc   = tcc_pkg::TOP_CAPTURE;
        topValue = capture_value;
        seqMode  = tcc_pkg::SEQ_UPDOWN;
      end
      4'h9, 4'hB:
      begin
        topSrc   = tcc_pkg::TOP_COMPARE;
        topValue = compareTop;
        seqMode  = tcc_pkg::SEQ_UPDOWN;
      end
      4'hC, 4'hE:
      begin
        topSrc   = tcc_pkg::TOP_CAPTURE;
        topValue = capture_value;
        seqMode  = tcc_pkg::SEQ_UP_TOP;
      end
      default:
      begin
        seqMode  = tcc_pkg::SEQ_UP_MAX;
        topValue = tcc_pkg::COUNT_MAX;
      end
    endcase
  end
  assign captureIsTop = (topSrc == tcc_pkg::TOP_CAPTURE);

  // External pin synchronised and edge detected
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      extSyncA <= 1'b0;
      extSyncB <= 1'b0;
      extLast  <= 1'b0;
    end
    else
    begin
      extSyncA <= external_count_pin;
      extSyncB <= extSyncA;
      extLast  <= extSyncB;
    end
  end

  // Tick select: stopped, prescaler taps, external falling/rising
  always_comb
  begin
    case (tick_source_select)
      3'h0: timer_tick = 1'b0; // [R07]
      3'h6: timer_tick = extLast && !extSyncB;
      3'h7: timer_tick = !extLast && extSyncB;
      default: timer_tick = prescaleTicks[tick_source_select]; // [R02]
    endcase
  end

  assign countBottom = (timer_count == tcc_pkg::COUNT_BOTTOM); // [R03] [R24]
  assign atTop       = (timer_count == topValue);
  assign countTop    = atTop;

  // Counter next value; CPU write has priority
  always_comb
  begin
    next_count     = timer_count;
    next_countDown = countDown;
    overflowEvent  = 1'b0;
    if (wrCountLo)
      next_count = {holdByte, cpuWdata}; // [R08] [R05] [R23]
    else if (timer_tick)
    begin
      case (seqMode)
        tcc_pkg::SEQ_UP_TOP:
        begin
          if (atTop)
          begin
            next_count    = tcc_pkg::COUNT_BOTTOM; // [R06]
            overflowEvent = (waveform_mode_field != 4'h4)
                            && (waveform_mode_field != 4'hC); // [R10]
          end
          else
            next_count = timer_count + tcc_pkg::COUNT_ONE;
        end
        tcc_pkg::SEQ_UPDOWN:
        begin
          if (countDown && countBottom)
          begin
            next_countDown = 1'b0;
            next_count     = timer_count + tcc_pkg::COUNT_ONE;
            overflowEvent  = 1'b1; // [R10]
          end
          else if (!countDown && atTop)
          begin
            next_countDown = 1'b1;
            next_count     = timer_count - tcc_pkg::COUNT_ONE;
          end
          else if (countDown)
            next_count = timer_count - tcc_pkg::COUNT_ONE; // [R03]
          else
            next_count = timer_count + tcc_pkg::COUNT_ONE;
        end
        default:
        begin
          next_count    = timer_count + tcc_pkg::COUNT_ONE;
          overflowEvent = (timer_count == tcc_pkg::COUNT_MAX); // [R24]
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timer_count <= tcc_pkg::COUNT_BOTTOM;
      countDown   <= 1'b0;
    end
    else
    begin
      timer_count <= next_count;
      countDown   <= next_countDown;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timer_control_first  <= tcc_pkg::CTRL_RESET;
      timer_control_second <= tcc_pkg::CTRL_RESET;
    end
    else if (cpuWrite && cpuSel == tcc_pkg::SEL_CTRL_A)
      timer_control_first <= cpuWdata;
    else if (cpuWrite && cpuSel == tcc_pkg::SEL_CTRL_B)
      timer_control_second <= cpuWdata;
  end

  // Shared holding register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      holdByte <= tcc_pkg::BYTE_ZERO;
    else if (wrHold)
      holdByte <= cpuWdata; // [R04]
    else if (rdCountLo)
      holdByte <= timer_count[15:8]; // [R05]
    else if (rdCaptLo)
      holdByte <= capture_value[15:8]; // [R14]
  end

  // Capture source and filter
  assign captureSource = comparator_capture_select ? comparator_output
                                                   : capture_pin; // [R17] [R22]
  tcc_capture_filter u_filter
  (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .enable     (!captureIsTop), // [R20]
    .filterOn   (timer_control_second[tcc_pkg::CTRLB_FILT]), // [R19]
    .risingEdge (timer_control_second[tcc_pkg::CTRLB_EDGE]),
    .rawIn      (captureSource),
    .event_p    (captureEvent)
  );

  // Capture register: event copy or top write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      capture_value <= tcc_pkg::COUNT_BOTTOM;
    else if (wrCaptLo && captureIsTop)
      capture_value <= {holdByte, cpuWdata}; // [R15] [R23]
    else if (captureEvent)
      capture_value <= timer_count; // [R11] [R21]
  end

  // Flags: set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      capture_flag <= 1'b0;
    else if (captureEvent)
      capture_flag <= 1'b1; // [R12]
    else if (captureIrqAck || captureFlagClear)
      capture_flag <= 1'b0; // [R13]
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      counter_overflow_flag <= 1'b0;
    else if (overflowEvent && !wrCountLo)
      counter_overflow_flag <= 1'b1; // [R10]
    else if (overflowIrqAck || overflowFlagClear)
      counter_overflow_flag <= 1'b0;
  end

  assign captureIrq  = capture_irq_enable && capture_flag; // [R13]
  assign overflowIrq = overflow_irq_enable && counter_overflow_flag;

  // Read data; upper locations return holder
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cpuRdata <= tcc_pkg::BYTE_ZERO;
    else if (cpuRead)
    begin
      if (cpuSel == tcc_pkg::SEL_COUNT_LO)
        cpuRdata <= timer_count[7:0];
      else if (cpuSel == tcc_pkg::SEL_CAPT_LO)
        cpuRdata <= capture_value[7:0];
      else if (cpuSel == tcc_pkg::SEL_COUNT_HI
               || cpuSel == tcc_pkg::SEL_CAPT_HI)
        cpuRdata <= holdByte; // [R04] [R14]
      else if (cpuSel == tcc_pkg::SEL_CTRL_A)
        cpuRdata <= timer_control_first;
      else if (cpuSel == tcc_pkg::SEL_CTRL_B)
        cpuRdata <= timer_control_second;
      else
        cpuRdata <= tcc_pkg::BYTE_ZERO;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tcc_pkg.sv
// Package: constants, modes and field layouts of the timer counter block
`default_nettype none
package tcc_pkg;
  localparam logic [15:0] COUNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  // Register selects on the byte port
  localparam logic [2:0]  SEL_COUNT_LO  = 3'h0;
  localparam logic [2:0]  SEL_COUNT_HI  = 3'h1;
  localparam logic [2:0]  SEL_CAPT_LO   = 3'h2;
  localparam logic [2:0]  SEL_CAPT_HI   = 3'h3;
  localparam logic [2:0]  SEL_CTRL_A    = 3'h4;
  localparam logic [2:0]  SEL_CTRL_B    = 3'h5;
  // Control register fields
  localparam int CTRLA_WGM_LO = 0;
  localparam int CTRLB_CS_LO  = 0;
  localparam int CTRLB_WGM_LO = 3;
  localparam int CTRLB_EDGE   = 6;
  localparam int CTRLB_FILT   = 7;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Noise filter depth in samples
  localparam int FILTER_SAMPLES = 4;
  typedef enum logic [1:0] {SEQ_UP_MAX, SEQ_UP_TOP, SEQ_UPDOWN} tcc_seq_t;
  typedef enum logic [1:0] {TOP_FIXED, TOP_COMPARE, TOP_CAPTURE} tcc_topsrc_t;
endpackage
`default_nettype wire

// ### hdl/tcc_capture_filter.sv
// Capture input synchroniser, noise filter and edge qualifier
`timescale 1ns/1ns
`default_nettype none
module tcc_capture_filter
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Control
  input  wire logic enable,
  input  wire logic filterOn,
  input  wire logic risingEdge,
  // Raw input and event
  input  wire logic rawIn,
  output logic      event_p
);
  logic       syncA;
  logic       syncB;
  logic [3:0] samples;
  logic       filtered;
  logic       next_filtered;
  logic       lastLevel;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end
    else
    begin
      syncA <= rawIn; // [R26]
      syncB <= syncA;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      samples <= 4'h0;
    else
      samples <= {samples[2:0], syncB};
  end

  // Four equal samples needed to change the filtered level
  always_comb
  begin
    next_filtered = filtered;
    if (!filterOn)
      next_filtered = syncB;
    else if (samples == 4'hF)
      next_filtered = 1'b1; // [R18]
    else if (samples == 4'h0)
      next_filtered = 1'b0; // [R18]
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      filtered  <= 1'b0;
      lastLevel <= 1'b0;
    end
    else
    begin
      filtered  <= next_filtered;
      lastLevel <= filtered;
    end
  end

  assign event_p = enable && (filtered != lastLevel)
                   && (filtered == risingEdge); // [R25] [R20]
endmodule
`default_nettype wire

// ### verification/tcc_timer16_properties.sv
// Port checker of the timer counter block
`timescale 1ns/1ns
`default_nettype none
module tcc_timer16_checker
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Byte port
  input wire logic [2:0]  cpuSel,
  input wire logic        cpuRead,
  input wire logic        cpuWrite,
  input wire logic [7:0]  cpuWdata,
  input wire logic [7:0]  cpuRdata,
  // Counter and flags
  input wire logic [15:0] timer_count,
  input wire logic        countTop,
  input wire logic        countBottom,
  input wire logic        timer_tick,
  input wire logic        capture_flag,
  input wire logic        capture_irq_enable,
  input wire logic        captureIrq,
  input wire logic        counter_overflow_flag,
  input wire logic        overflow_irq_enable,
  input wire logic        overflowIrq,
  input wire logic        overflowFlagClear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence wrPair;
    cpuWrite && cpuSel == tcc_pkg::SEL_COUNT_HI
      ##1 cpuWrite && cpuSel == tcc_pkg::SEL_COUNT_LO;
  endsequence
  sequence rdPair;
    cpuRead && cpuSel == tcc_pkg::SEL_COUNT_LO
      ##1 cpuRead && cpuSel == tcc_pkg::SEL_COUNT_HI;
  endsequence
  chk_count_write16: assert property (
    wrPair |=> timer_count == {$past(cpuWdata, 2), $past(cpuWdata)})
    else $error("count differs from written pair");
  chk_count_rdpair: assert property (
    rdPair |=> cpuRdata == $past(timer_count[15:8], 2))
    else $error("upper count byte not held");
  chk_low_read: assert property (
    cpuRead && cpuSel == tcc_pkg::SEL_COUNT_LO
      |=> cpuRdata == $past(timer_count[7:0]))
    else $error("lower count byte wrong");
  chk_rdata_hold: assert property (
    !cpuRead |=> $stable(cpuRdata))
    else $error("read data moved without read");
  chk_count_idle: assert property (
    !timer_tick && !cpuWrite |=> $stable(timer_count))
    else $error("count moved without tick");
  chk_tick_moves: assert property (
    timer_tick && !cpuWrite && !countTop
      |=> timer_count != $past(timer_count))
    else $error("tick left count unchanged");
  chk_bottom_flag: assert property (
    countBottom == (timer_count == tcc_pkg::COUNT_BOTTOM))
    else $error("bottom indication wrong");
  chk_capt_irq: assert property (
    captureIrq == (capture_irq_enable && capture_flag))
    else $error("capture request wrong");
  chk_ovf_irq: assert property (
    overflowIrq == (overflow_irq_enable && counter_overflow_flag))
    else $error("overflow request wrong");
  chk_ovf_clear: assert property (
    overflowFlagClear && !timer_tick |=> !counter_overflow_flag)
    else $error("overflow flag not cleared");
endmodule
bind tcc_timer16 tcc_timer16_checker i_chk
(
  .clk_sys, .sys_rst, .cpuSel, .cpuRead, .cpuWrite, .cpuWdata, .cpuRdata,
  .timer_count, .countTop, .countBottom, .timer_tick, .capture_flag,
  .capture_irq_enable, .captureIrq, .counter_overflow_flag,
  .overflow_irq_enable, .overflowIrq, .overflowFlagClear
);
`default_nettype wire

// ### verification/tcc_cpu_model.sv
// Byte-bus processor model driving the timer block
`timescale 1ns/1ns
`default_nettype none
module tcc_cpu_model
(
  // Clock
  input  wire logic       clk_sys,
  // Byte port towards the timer
  output var logic [2:0]  cpuSel,
  output var logic        cpuRead,
  output var logic        cpuWrite,
  output var logic [7:0]  cpuWdata,
  input  wire logic [7:0] cpuRdata
);
  initial
  begin
    cpuSel = 3'h7;
    cpuRead = 1'b0;
    cpuWrite = 1'b0;
    cpuWdata = 8'hA5;
  end
  // Single byte access
  task automatic acc(input logic wr, input logic [2:0] sel,
                     input logic [7:0] d);
    @(negedge clk_sys);
    cpuSel = sel;
    cpuWrite = wr;
    cpuRead = !wr;
    cpuWdata = d;
    @(negedge clk_sys);
    cpuRead = 1'b0;
    cpuWrite = 1'b0;
    cpuWdata = ~d;
  endtask
  // Unbroken pair: writes upper first, reads lower first
  task automatic pair(input logic wr, input logic [2:0] lo,
                      input logic [15:0] v, output logic [15:0] rv);
    @(negedge clk_sys);
    cpuSel = wr ? lo + 3'h1 : lo;
    cpuWrite = wr;
    cpuRead = !wr;
    cpuWdata = v[15:8];
    @(negedge clk_sys);
    rv[7:0] = cpuRdata;
    cpuSel = wr ? lo : lo + 3'h1;
    cpuWdata = v[7:0];
    @(negedge clk_sys);
    rv[15:8] = cpuRdata;
    cpuRead = 1'b0;
    cpuWrite = 1'b0;
    cpuWdata = ~v[7:0];
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the timer counter block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  cpuSel;
  logic        cpuRead, cpuWrite, timer_tick, countTop, countBottom;
  logic [7:0]  cpuWdata, cpuRdata;
  logic [7:0]  prescaleTicks = 8'h00;
  logic        external_count_pin = 1'b0, capture_pin = 1'b0;
  logic        comparator_output = 1'b0, comparator_capture_select = 1'b0;
  logic        capture_irq_enable = 1'b0, overflow_irq_enable = 1'b0;
  logic        captureIrqAck = 1'b0, overflowIrqAck = 1'b0;
  logic        captureFlagClear = 1'b0, overflowFlagClear = 1'b0;
  logic        capture_flag, counter_overflow_flag, captureIrq, overflowIrq;
  logic [15:0] compareTop = 16'h0000, timer_count, rv, v, expCap = 16'h0000;
  logic [31:0] seed = 32'hED07977D;
  logic [7:0]  ctlTab [6] = '{8'h40, 8'h00, 8'hC0, 8'hC0, 8'h40, 8'h18};
  int          holdTab [6] = '{8, 8, 5, 3, 8, 8};
  logic [5:0]  earlyTab = 6'b010001;
  logic [5:0]  finalTab = 6'b010111;
  int          mismatches = 0, n_tests = 0, n;
  always #5 clk_sys = ~clk_sys;
  tcc_timer16 i_tcc_timer16 (.clk_sys, .sys_rst, .cpuSel, .cpuRead,
    .cpuWrite, .cpuWdata, .cpuRdata, .prescaleTicks, .external_count_pin,
    .capture_pin, .comparator_output, .comparator_capture_select,
    .capture_irq_enable, .overflow_irq_enable, .captureIrqAck,
    .overflowIrqAck, .captureFlagClear, .overflowFlagClear, .capture_flag,
    .counter_overflow_flag, .captureIrq, .overflowIrq, .compareTop,
    .timer_count, .countTop, .countBottom, .timer_tick);
  tcc_cpu_model i_tcc_cpu_model (.clk_sys, .cpuSel, .cpuRead, .cpuWrite,
    .cpuWdata, .cpuRdata);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Whether tick select s sees a tick this cycle
  function automatic int hit(input int s, input logic [7:0] pt,
                             input logic o, input logic nx);
    if (s < 6)
      return int'(pt[s]);
    return int'(s == 7 ? !o && nx : o && !nx);
  endfunction
  // Count after k ticks of an up/down sequence starting upwards
  function automatic logic [15:0] updown(input logic [15:0] c, input int k,
                                         input logic [15:0] top);
    logic dn;
    dn = 1'b0;
    repeat (k)
    begin
      if (c == top)
        dn = 1'b1;
      else if (c == 16'h0000)
        dn = 1'b0;
      c = dn ? c - 16'h0001 : c + 16'h0001;
    end
    return c;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic pulse(input int hold, input logic early);
    @(negedge clk_sys);
    if (comparator_capture_select)
      comparator_output = 1'b1;
    else
      capture_pin = 1'b1;
    cyc(hold);
    chk("flag before drop", capture_flag, early);
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    cyc(12);
  endtask
  task automatic clrCap(input logic useAck);
    captureIrqAck = useAck;
    captureFlagClear = !useAck;
    cyc(1);
    captureIrqAck = 1'b0;
    captureFlagClear = 1'b0;
    cyc(1);
    chk("capture flag cleared", capture_flag, 0);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    cyc(10);
    sys_rst = 1'b0;
    compareTop = seed[31:16];
    i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_COUNT_LO, 16'h01FF, rv);
    cyc(3);
    i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_COUNT_LO, 16'h0000, rv);
    chk("stopped count", rv, 16'h01FF);
    for (int s = 1; s < 8; s++)
    begin
      i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_COUNT_LO, 16'hFFF8, rv);
      i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'(s));
      n = 0;
      repeat (24)
      begin
        seed = lfsr(seed);
        prescaleTicks = seed[7:0];
        overflow_irq_enable = seed[12];
        n += hit(s, seed[7:0], external_count_pin, seed[9]);
        external_count_pin = seed[9];
        cyc(1);
      end
      prescaleTicks = 8'h00;
      cyc(5);
      i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'h00);
      i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_COUNT_LO, 16'h0000, rv);
      chk("ticked count", rv, 16'hFFF8 + 16'(n));
      chk("overflow flag", counter_overflow_flag, n > 7);
      overflowFlagClear = s[0];
      overflowIrqAck = !s[0];
      cyc(1);
      overflowFlagClear = 1'b0;
      overflowIrqAck = 1'b0;
      cyc(1);
      chk("overflow cleared", counter_overflow_flag, 0);
    end
    i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_COUNT_LO, 16'h00FB, rv);
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_A, 8'h01);
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'h01);
    seed = lfsr(seed);
    n = 8 + int'(seed[3:0]);
    prescaleTicks = 8'h02;
    cyc(n);
    prescaleTicks = 8'h00;
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'h00);
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_A, 8'h00);
    i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_COUNT_LO, 16'h0000, rv);
    chk("updown count", rv,
        updown(16'h00FB, n, tcc_pkg::TOP_8BIT));
    chk("no overflow at top", counter_overflow_flag, 0);
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'h01);
    prescaleTicks = 8'hFF;
    i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_COUNT_LO, 16'h1234, rv);
    prescaleTicks = 8'h00;
    i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, 8'h00);
    i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_COUNT_LO, 16'h0000, rv);
    chk("write beats tick", rv, 16'h1234);
    i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_CAPT_LO, 16'h5A5A, rv);
    i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_CAPT_LO, 16'h0000, rv);
    chk("capture write ignored", rv, expCap);
    i_tcc_cpu_model.pair(1'b0, 3'h6, 16'h0000, rv);
    chk("unmapped read", rv, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = seed[15:0];
      capture_irq_enable = seed[16];
      comparator_capture_select = i == 4;
      i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_COUNT_LO, v, rv);
      i_tcc_cpu_model.acc(1'b1, tcc_pkg::SEL_CTRL_B, ctlTab[i]);
      if (i == 5)
      begin
        i_tcc_cpu_model.pair(1'b1, tcc_pkg::SEL_CAPT_LO, v, rv);
        expCap = v;
      end
      clrCap(i[0]);
      pulse(holdTab[i], earlyTab[i]);
      chk("capture flag", capture_flag, finalTab[i]);
      if (finalTab[i])
        expCap = v;
      if (i != 0)
      begin
        i_tcc_cpu_model.pair(1'b0, tcc_pkg::SEL_CAPT_LO, 16'h0000, rv);
        chk("capture value", rv, expCap);
      end
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
